// *** verilog/sust_store_unit.sv ***
`timescale 1ns/1ps
module sust_store_unit
(
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    // store issue from the core
    input  wire logic                        issue_valid,
    input  wire sust_pkg::sust_size_t        issue_size,
    input  wire logic                        issue_imm_form,
    input  wire logic                        issue_reverse,
    input  wire logic [4:0]                  issue_src_reg,
    input  wire logic [31:0]                 reg_a,
    input  wire logic [31:0]                 reg_b,
    input  wire logic [15:0]                 imm_field,
    input  wire logic [31:0]                 store_data,
    input  wire logic                        imm_prefix_valid,
    input  wire logic [15:0]                 imm_prefix_hi,
    output logic                             busy_r,
    output logic                             done_r,
    // configuration
    input  wire logic                        area_optimized_option,
    input  wire logic                        big_endian_cfg,
    // translation lookup for the address of the issued store
    input  wire logic                        tlb_miss,
    input  wire logic                        zone_no_access,
    input  wire logic                        zone_read_only,
    input  wire logic                        page_endian_bit,
    // machine status mode bits
    input  wire logic                        mode_wr,
    input  wire logic [3:0]                  mode_wdata,
    output logic                             user_mode_bit_r,
    output logic                             virtual_mode_bit_r,
    output logic                             saved_user_mode_bit_r,
    output logic                             saved_virtual_mode_bit_r,
    // exception status
    output logic                             exc_valid_r,
    output logic [4:0]                       exception_cause_code_r,
    output logic                             exc_store_r,
    output logic                             exc_word_r,
    output logic [4:0]                       exc_src_reg_r,
    output logic                             no_access_zone_flag_r,
    // data memory write port
    output logic                             mem_wr_en_r,
    output logic [31:0]                      mem_addr_r,
    output logic [3:0]                       mem_be_r,
    output logic [31:0]                      mem_wdata_r
);

    ////////////////////////////////////////////////////////////////////////////////////////
    // lane placement: lane k carries the byte at address offset k
    function automatic logic [35:0] sust_place(sust_pkg::sust_size_t sz, logic [1:0] lane,
                                                logic big, logic [31:0] d);
        logic [31:0] w;
        logic [3:0]  be;
        logic [15:0] h;
        w  = 32'h0000_0000;
        be = 4'h0;
        h  = big ? {d[7:0], d[15:8]} : d[15:0];
        unique case (sz)
            sust_pkg::SUST_SZ_BYTE:
            begin
                w  = {4{d[7:0]}};
                be = sust_pkg::SUST_BE_BYTE << lane;
            end
            sust_pkg::SUST_SZ_HALF:
            begin
                w  = {2{h}};
                be = sust_pkg::SUST_BE_HALF << {lane[1], 1'b0};
            end
            default:
            begin
                w  = big ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
                be = sust_pkg::SUST_BE_WORD;
            end
        endcase
        return {be, w};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////
    // effective address
    logic [31:0] offset;
    logic [31:0] eff_addr;
    logic        rev;
    logic        eff_big;
    logic [1:0]  lane;
    logic [35:0] placed;
    logic        accept;

    assign accept = issue_valid & ~busy_r;

    // a prefix supplies the upper half; otherwise sign-extend the 16-bit field
    always_comb
    begin
        if (!issue_imm_form)
        begin
            offset = reg_b;
        end
        else if (imm_prefix_valid)
        begin
            offset = {imm_prefix_hi, imm_field};
        end
        else
        begin
            offset = {{(32 - sust_pkg::SUST_IMM_W){imm_field[15]}}, imm_field};
        end
    end

    assign eff_addr = reg_a + offset;

    // reverse only exists on register forms; the page bit only counts with vm on
    assign rev     = issue_reverse & ~issue_imm_form;
    assign eff_big = big_endian_cfg ^ (virtual_mode_bit_r & page_endian_bit) ^ rev;
    assign lane    = eff_addr[1:0] ^ (rev ? sust_pkg::SUST_LANE_FLIP : 2'h0);
    assign placed  = sust_place(issue_size, lane, eff_big, store_data);

    ////////////////////////////////////////////////////////////////////////////////////////
    // exception checks live in their own module
    sust_chk_if chk_bus ();

    assign chk_bus.addr           = eff_addr;
    assign chk_bus.size           = issue_size;
    assign chk_bus.user_mode      = user_mode_bit_r;
    assign chk_bus.virt_mode      = virtual_mode_bit_r;
    assign chk_bus.tlb_miss       = tlb_miss;
    assign chk_bus.zone_no_access = zone_no_access;
    assign chk_bus.zone_read_only = zone_read_only;

    sust_check u_check
    (
        .c (chk_bus.chk)
    );

    ////////////////////////////////////////////////////////////////////////////////////////
    // result of the current issue
    sust_pkg::sust_res_t live_res;
    sust_pkg::sust_res_t pend_res_r;
    sust_pkg::sust_res_t commit_res;
    logic                pend_v_r;
    logic                commit;

    always_comb
    begin
        live_res.kind      = chk_bus.kind;
        live_res.no_access = chk_bus.no_access;
        live_res.src_reg   = issue_src_reg;
        live_res.is_word   = (issue_size == sust_pkg::SUST_SZ_WORD);
        live_res.addr      = eff_addr;
        live_res.be        = placed[35:32];
        live_res.wdata     = placed[31:0];
    end

    // the area option parks the result one cycle; trades a cycle for less logic
    assign commit     = pend_v_r | (accept & ~area_optimized_option);
    assign commit_res = pend_v_r ? pend_res_r : live_res;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pend_v_r   <= 1'b0;
            busy_r     <= 1'b0;
            pend_res_r <= '0;
        end
        else
        begin
            pend_v_r <= accept & area_optimized_option;
            busy_r   <= accept & area_optimized_option;
            if (accept)
            begin
                pend_res_r <= live_res;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // memory port; a faulting store never reaches memory
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            mem_wr_en_r <= 1'b0;
            mem_addr_r  <= 32'h0000_0000;
            mem_be_r    <= 4'h0;
            mem_wdata_r <= 32'h0000_0000;
            done_r      <= 1'b0;
        end
        else
        begin
            done_r      <= commit;
            mem_wr_en_r <= commit && commit_res.kind == sust_pkg::SUST_EXC_NONE;
            if (commit && commit_res.kind == sust_pkg::SUST_EXC_NONE)
            begin
                mem_addr_r  <= commit_res.addr;
                mem_be_r    <= commit_res.be;
                mem_wdata_r <= commit_res.wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // exception status; fields not named by a fault keep their value
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            exc_valid_r            <= 1'b0;
            exception_cause_code_r <= sust_pkg::SUST_CAUSE_RST;
            exc_store_r            <= 1'b0;
            exc_word_r             <= 1'b0;
            exc_src_reg_r          <= 5'h00;
            no_access_zone_flag_r  <= 1'b0;
        end
        else
        begin
            exc_valid_r <= commit && commit_res.kind != sust_pkg::SUST_EXC_NONE;
            if (commit)
            begin
                unique case (commit_res.kind)
                    sust_pkg::SUST_EXC_TLB:
                    begin
                        exception_cause_code_r <= sust_pkg::SUST_CAUSE_TLB_MISS;
                        exc_store_r            <= 1'b1;
                    end
                    sust_pkg::SUST_EXC_DSTORE:
                    begin
                        exception_cause_code_r <= sust_pkg::SUST_CAUSE_DSTORAGE;
                        exc_store_r            <= 1'b1;
                        no_access_zone_flag_r  <= commit_res.no_access;
                    end
                    sust_pkg::SUST_EXC_UNALIGN:
                    begin
                        exception_cause_code_r <= sust_pkg::SUST_CAUSE_UNALIGNED;
                        exc_store_r            <= 1'b1;
                        exc_word_r             <= commit_res.is_word;
                        exc_src_reg_r          <= commit_res.src_reg;
                    end
                    sust_pkg::SUST_EXC_NONE:
                    begin
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // mode bits; an mmu fault wins over a core write in the same cycle
    logic mmu_fault;

    assign mmu_fault = commit && (commit_res.kind == sust_pkg::SUST_EXC_TLB ||
                                  commit_res.kind == sust_pkg::SUST_EXC_DSTORE);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            user_mode_bit_r          <= sust_pkg::SUST_MODE_RST;
            virtual_mode_bit_r       <= sust_pkg::SUST_MODE_RST;
            saved_user_mode_bit_r    <= sust_pkg::SUST_MODE_RST;
            saved_virtual_mode_bit_r <= sust_pkg::SUST_MODE_RST;
        end
        else if (mmu_fault)
        begin
            saved_user_mode_bit_r    <= user_mode_bit_r;
            saved_virtual_mode_bit_r <= virtual_mode_bit_r;
            user_mode_bit_r          <= 1'b0;
            virtual_mode_bit_r       <= 1'b0;
        end
        else if (mode_wr)
        begin
            user_mode_bit_r          <= mode_wdata[0];
            virtual_mode_bit_r       <= mode_wdata[1];
            saved_user_mode_bit_r    <= mode_wdata[2];
            saved_virtual_mode_bit_r <= mode_wdata[3];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    logic fast_acc;
    assign fast_acc = accept & ~area_optimized_option & ~mode_wr;

    a_fast_latency: assert property (accept && !area_optimized_option |=> done_r)
        else $error("store did not finish in one cycle");
    a_area_latency: assert property (
            accept && area_optimized_option |=> !done_r ##1 done_r)
        else $error("area store did not finish in two cycles");
    a_exc_no_write: assert property (exc_valid_r |-> !mem_wr_en_r)
        else $error("memory written on a faulting store");
    a_mode_cleared: assert property (
            exc_valid_r && exception_cause_code_r != sust_pkg::SUST_CAUSE_UNALIGNED
            |-> !user_mode_bit_r && !virtual_mode_bit_r)
        else $error("mode bits not cleared on mmu fault");
    a_vm_off_only_align: assert property (
            fast_acc && !virtual_mode_bit_r
            |=> !exc_valid_r || exception_cause_code_r == sust_pkg::SUST_CAUSE_UNALIGNED)
        else $error("mmu fault with vm clear");
    a_word_full: assert property (
            fast_acc && !virtual_mode_bit_r &&
            issue_size == sust_pkg::SUST_SZ_WORD && eff_addr[1:0] == 2'h0
            |=> mem_wr_en_r && mem_be_r == 4'hf && mem_addr_r == $past(eff_addr))
        else $error("clean word store not written whole");
    a_half_unalign: assert property (
            fast_acc && !virtual_mode_bit_r &&
            issue_size == sust_pkg::SUST_SZ_HALF && eff_addr[0]
            |=> exc_valid_r && exception_cause_code_r == 5'h01 && !exc_word_r
                && exc_src_reg_r == $past(issue_src_reg))
        else $error("odd halfword not reported");
    a_word_unalign: assert property (
            fast_acc && !virtual_mode_bit_r &&
            issue_size == sust_pkg::SUST_SZ_WORD && eff_addr[1:0] != 2'h0
            |=> exc_valid_r && exception_cause_code_r == 5'h01 && exc_word_r)
        else $error("misaligned word not reported");
    a_tlb_first: assert property (
            fast_acc && virtual_mode_bit_r && tlb_miss
            |=> exc_valid_r && exception_cause_code_r == 5'h12 && exc_store_r)
        else $error("miss not given priority");
    a_noaccess_super: assert property (
            fast_acc && virtual_mode_bit_r && !tlb_miss &&
            !user_mode_bit_r && zone_no_access && !zone_read_only &&
            issue_size == sust_pkg::SUST_SZ_BYTE |=> !exc_valid_r)
        else $error("no-access fault in supervisor mode");

    c_byte_store: cover property (accept && issue_size == sust_pkg::SUST_SZ_BYTE ##1 mem_wr_en_r);
    c_dstore_exc: cover property (exc_valid_r && exception_cause_code_r == 5'h10);
    c_area_store: cover property (accept && area_optimized_option ##2 mem_wr_en_r);

endmodule

// *** shared/sust_pkg.sv ***
package sust_pkg;

    ////////////////////////////////////////////////////////////////////////////////////////
    // widths and field positions
    localparam int          SUST_WORD_W      = 32;
    localparam int          SUST_IMM_W       = 16;
    localparam int          SUST_REGNUM_W    = 5;
    localparam int          SUST_CAUSE_W     = 5;
    localparam logic [1:0]  SUST_LANE_FLIP   = 2'h3;   // byte-reversed location within a word
    localparam logic [3:0]  SUST_BE_BYTE     = 4'h1;
    localparam logic [3:0]  SUST_BE_HALF     = 4'h3;
    localparam logic [3:0]  SUST_BE_WORD     = 4'hf;

    ////////////////////////////////////////////////////////////////////////////////////////
    // exception cause codes
    localparam logic [4:0]  SUST_CAUSE_UNALIGNED = 5'h01;
    localparam logic [4:0]  SUST_CAUSE_DSTORAGE  = 5'h10;
    localparam logic [4:0]  SUST_CAUSE_TLB_MISS  = 5'h12;

    ////////////////////////////////////////////////////////////////////////////////////////
    // reset values and latency
    localparam logic        SUST_MODE_RST    = 1'b0;
    localparam logic [4:0]  SUST_CAUSE_RST   = 5'h00;
    localparam int          SUST_LAT_FAST    = 1;      // cycles, area option off
    localparam int          SUST_LAT_AREA    = 2;      // cycles, area option on

    ////////////////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {SUST_SZ_BYTE, SUST_SZ_HALF, SUST_SZ_WORD} sust_size_t;
    typedef enum logic [1:0] {SUST_EXC_NONE, SUST_EXC_TLB, SUST_EXC_DSTORE,
                              SUST_EXC_UNALIGN} sust_exc_t;

    typedef struct packed {
        sust_exc_t                  kind;
        logic                       no_access;
        logic [SUST_REGNUM_W-1:0]   src_reg;
        logic                       is_word;
        logic [SUST_WORD_W-1:0]     addr;
        logic [3:0]                 be;
        logic [SUST_WORD_W-1:0]     wdata;
    } sust_res_t;

endpackage

// *** shared/sust_chk_if.sv ***
`timescale 1ns/1ps
interface sust_chk_if;
    logic [31:0]           addr;
    sust_pkg::sust_size_t  size;
    logic                  user_mode;
    logic                  virt_mode;
    logic                  tlb_miss;
    logic                  zone_no_access;
    logic                  zone_read_only;
    sust_pkg::sust_exc_t   kind;
    logic                  no_access;

    modport chk  (input addr, size, user_mode, virt_mode, tlb_miss, zone_no_access,
                  zone_read_only, output kind, no_access);
    modport user (output addr, size, user_mode, virt_mode, tlb_miss, zone_no_access,
                  zone_read_only, input kind, no_access);
endinterface

// *** verilog/sust_check.sv ***
`timescale 1ns/1ps
module sust_check
(
    // link to the store datapath
    sust_chk_if.chk  c
);

    ////////////////////////////////////////////////////////////////////////////////////////
    // protection: no-access only counts in user mode, read-only always
    logic protect;
    logic misalign;

    assign protect = (c.zone_no_access & c.user_mode) | c.zone_read_only;

    // alignment by access size, bytes can never be misaligned
    always_comb
    begin
        unique case (c.size)
            sust_pkg::SUST_SZ_HALF: misalign = c.addr[0];
            sust_pkg::SUST_SZ_WORD: misalign = |c.addr[1:0];
            default:                misalign = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // fixed priority: miss, then protection, then alignment; mmu checks need vm set
    always_comb
    begin
        c.no_access = 1'b0;
        if (c.virt_mode && c.tlb_miss)
        begin
            c.kind = sust_pkg::SUST_EXC_TLB;
        end
        else if (c.virt_mode && protect)
        begin
            c.kind      = sust_pkg::SUST_EXC_DSTORE;
            c.no_access = c.zone_no_access & c.user_mode;
        end
        else if (misalign)
        begin
            c.kind = sust_pkg::SUST_EXC_UNALIGN;
        end
        else
        begin
            c.kind = sust_pkg::SUST_EXC_NONE;
        end
    end

endmodule

// *** tb/sust_mem_model.sv ***
`timescale 1ns/1ps
// byte memory on the far side of the store write port
module sust_mem_model
(
    // clock
    input  wire logic        clk,
    // write port
    input  wire logic        wr_en,
    input  wire logic [31:0] addr,
    input  wire logic [3:0]  be,
    input  wire logic [31:0] wdata
);
    logic [7:0] mem [int];
    int         n_wr = 0;
    ////////////////////////////////////////////////////////////////////////
    // take the enabled lanes of the addressed word on the write pulse
    always @(posedge clk)
    begin
        if (wr_en === 1'b1)
        begin
            n_wr++;
            for (int k = 0; k < 4; k++)
                if (be[k])
                    mem[int'({addr[31:2], 2'b00}) + k] = wdata[8*k +: 8];
        end
    end
    // a byte never written reads as a pattern that moves, not a stale value
    function automatic logic [7:0] rd(input logic [31:0] a);
        return mem.exists(int'(a)) ? mem[int'(a)] : 8'(n_wr) ^ 8'ha5;
    endfunction
endmodule

// *** tb/tb_store_unit_byte_half_word.sv ***
`timescale 1ns/1ps
module tb_store_unit_byte_half_word;
    logic                 clk = 0, rst_n = 0, iv = 0, imf = 0, rev = 0, pv = 0, ao = 0;
    logic                 big = 0, miss = 0, na = 0, ro = 0, pg = 0, mwr = 0;
    logic                 xs, xw, xnaf;
    logic [3:0]           mwd = 0, mode;
    logic [4:0]           src = 0, xc, xsrc;
    logic [15:0]          imm = 0, phi = 0;
    logic [31:0]          ra = 0, rb = 0, sd = 0;
    sust_pkg::sust_size_t sz = sust_pkg::SUST_SZ_BYTE;
    logic                 busy, done, usr, virt, usr_sv, virt_sv, exv, es, ew, naf, wen;
    logic [4:0]           cause, esrc;
    logic [3:0]           mbe;
    logic [31:0]          maddr, mwdata;
    int                   fail_count = 0, n_tests = 0, nw = 0;

    sust_store_unit uut (.clk(clk), .rst_n(rst_n), .issue_valid(iv), .issue_size(sz),
        .issue_imm_form(imf), .issue_reverse(rev), .issue_src_reg(src), .reg_a(ra),
        .reg_b(rb), .imm_field(imm), .store_data(sd), .imm_prefix_valid(pv),
        .imm_prefix_hi(phi), .busy_r(busy), .done_r(done), .area_optimized_option(ao),
        .big_endian_cfg(big), .tlb_miss(miss), .zone_no_access(na), .zone_read_only(ro),
        .page_endian_bit(pg), .mode_wr(mwr), .mode_wdata(mwd), .user_mode_bit_r(usr),
        .virtual_mode_bit_r(virt), .saved_user_mode_bit_r(usr_sv),
        .saved_virtual_mode_bit_r(virt_sv), .exc_valid_r(exv), .exception_cause_code_r(cause),
        .exc_store_r(es), .exc_word_r(ew), .exc_src_reg_r(esrc),
        .no_access_zone_flag_r(naf), .mem_wr_en_r(wen), .mem_addr_r(maddr),
        .mem_be_r(mbe), .mem_wdata_r(mwdata));
    sust_mem_model mm (.clk(clk), .wr_en(wen), .addr(maddr), .be(mbe), .wdata(mwdata));

    always #50 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    // compare helpers and the single exit
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_mem(input logic [31:0] a, input logic [7:0] e);
        n_tests++;
        if (mm.rd(a) !== e)
        begin
            fail_count++;
            $display("mismatch mem %h expected %h seen %h", a, e, mm.rd(a));
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // reset for eight cycles, model state back to its cleared values
    task automatic do_reset();
        rst_n = 0;
        repeat (8) @(posedge clk);
        #1 rst_n = 1;
        {mode, xc, xs, xw, xsrc, xnaf} = '0;
        chk("reset mode", 0, {virt_sv, usr_sv, virt, usr});
        chk("reset outs", 0, {busy, done, exv, wen, cause, es, ew, esrc, naf});
        $display("test reset done");
    endtask
    task automatic set_mode(input logic [3:0] v);
        mwd = v;
        mwr = 1;
        @(posedge clk);
        #1 mwr = 0;
        mode = v;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // one store against the behavioural model
    task automatic store();
        logic [31:0] a, w, m;
        logic [3:0]  b;
        logic [4:0]  c;
        logic        e, r;
        int          n;
        r = rev & ~imf;
        a = ra + (imf ? (pv ? {phi, imm} : {{16{imm[15]}}, imm}) : rb);
        e = big ^ (mode[1] & pg) ^ r;
        c = 5'h00;
        if (mode[1] & miss) c = 5'h12;
        else if (mode[1] & ((na & mode[0]) | ro)) c = 5'h10;
        else if ((sz == sust_pkg::SUST_SZ_HALF && a[0])
                 || (sz == sust_pkg::SUST_SZ_WORD && a[1:0] != 0)) c = 5'h01;
        b = (sz == sust_pkg::SUST_SZ_BYTE) ? 4'h1 << (a[1:0] ^ {2{r}})
          : (sz == sust_pkg::SUST_SZ_HALF) ? 4'h3 << {a[1] ^ r, 1'b0} : 4'hf;
        w = (sz == sust_pkg::SUST_SZ_BYTE) ? {4{sd[7:0]}}
          : (sz == sust_pkg::SUST_SZ_HALF) ? {2{e ? {sd[7:0], sd[15:8]} : sd[15:0]}}
          : (e ? {sd[7:0], sd[15:8], sd[23:16], sd[31:24]} : sd);
        m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
        if (c == 5'h10) xnaf = na & mode[0];
        if (c == 5'h01) {xw, xsrc} = {sz == sust_pkg::SUST_SZ_WORD, src};
        else if (c != 0) mode = {mode[1:0], 2'b00};
        if (c != 0) {xc, xs} = {c, 1'b1};
        iv = 1;
        @(posedge clk);
        // with the area option the request stays up while busy; a second take would show
        #1 iv = ao;
        chk("busy", ao, busy);
        n = 1;
        while (done !== 1'b1 && n < 4)
        begin
            @(posedge clk);
            #1 n++;
            iv = 0;
        end
        chk("latency", ao ? 2 : 1, n);
        chk("exc", c != 0, exv);
        chk("wen", c == 0, wen);
        chk("status", {xc, xs, xw, xsrc, xnaf}, {cause, es, ew, esrc, naf});
        chk("mode", mode, {virt_sv, usr_sv, virt, usr});
        if (c == 0)
        begin
            nw++;
            chk("addr", a, maddr);
            chk("be", b, mbe);
            chk("data", w & m, mwdata & m);
        end
        @(posedge clk);
        #1;
        for (int k = 0; k < 4; k++)
            if (c == 0 && b[k]) chk_mem({a[31:2], 2'b00} + k, w[8*k +: 8]);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // main sequence: reset, random stores in both latency modes, with a second reset after store 199
    initial
    begin
        void'($urandom(32'h5a0e1587));
        do_reset();
        for (int i = 0; i < 400; i++)
        begin
            ao = (i / 50) % 2;
            if (i % 4 == 0) set_mode(4'($urandom));
            {imf, rev, pv, big, pg} = 5'($urandom);
            {miss, na, ro} = 3'($urandom) & 3'($urandom);
            sz = sust_pkg::sust_size_t'($urandom_range(2));
            {src, imm, phi} = 37'({$urandom, $urandom});
            {ra, rb, sd} = {$urandom, $urandom, $urandom};
            store();
            if (i == 199) do_reset();
        end
        chk("writes", nw, mm.n_wr);
        $display("test random stores done");
        complete_run();
    end
    // hang guard: about seven times the expected run length
    initial
    begin
        #(8000 * 100);
        fail_count++;
        complete_run();
    end
endmodule
